// ===== src/swc_pkg.sv
// Purpose: Shared constants and types for the sleep and wake controller.
// Assumes: Classic Wishbone with 32-bit data and byte addresses.
// Notes:   Registers take one aligned word each.
package swc_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] PEN_OFS     = 8'h04;
    localparam logic [7:0] RESET_CONTROL_REG_OFS    = 8'h08;
    localparam logic [7:0] IRQ_ST_OFS  = 8'h0C;
    localparam logic [7:0] IRQ_MSK_OFS = 8'h10;

    // Control register fields.
    localparam int CTRL_GIE_BIT  = 0;
    localparam int CTRL_WDTE_BIT = 1;
    localparam int CTRL_INTE_BIT = 2;
    localparam int CTRL_PBE_BIT  = 3;
    localparam int CTRL_W        = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Reset control register fields.
    localparam int RESET_CONTROL_REG_ASLEEP_BIT = 0;
    localparam int RESET_CONTROL_REG_PD_BIT     = 3;
    localparam int RESET_CONTROL_REG_TO_BIT     = 4;
    localparam logic PD_RST = 1'b1;
    localparam logic TO_RST = 1'b1;

    // Peripheral wake sources, one enable and one flag bit each.
    localparam int PER_PSP    = 0;
    localparam int PER_TIMER_ONE   = 1;
    localparam int PER_TIMER_THREE   = 2;
    localparam int PER_CAPT   = 3;
    localparam int PER_SPEVT  = 4;
    localparam int PER_SSPSS  = 5;
    localparam int PER_SSPXF  = 6;
    localparam int PER_USART  = 7;
    localparam int PER_ADC    = 8;
    localparam int PER_EEWR   = 9;
    localparam int PER_LVD    = 10;
    localparam int PER_W      = 11;
    localparam logic [10:0] PEN_RST = 11'h000;

    // Event status bits.
    localparam int EV_SLEEP = 0;
    localparam int EV_WINT  = 1;
    localparam int EV_WWDT  = 2;
    localparam int EV_NOP   = 3;
    localparam int EV_MASTER_CLEAR_PIN  = 4;
    localparam int EV_W     = 5;
    localparam logic [4:0] EV_RST = 5'h00;

    // Prefetch distance past the sleep instruction, in bytes.
    localparam logic [15:0] PREFETCH_STEP = 16'h0002;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b10
    } swc_state_e;

    typedef enum logic [1:0] {
        WK_INT  = 2'b00,
        WK_WDT  = 2'b01,
        WK_MASTER_CLEAR_PIN = 2'b10
    } swc_wake_e;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
    } swc_wb_req_s;

endpackage

// ===== src/swc_sleep_ctrl.sv
// Purpose: Sleep entry, wake-up and resume control for an 8-bit core.
// Assumes: All inputs synchronous to clk_i; wake sources hold until seen.
// Notes:   Wake sources are level flags; the core holds them until seen.
// Operation
// - Sleep clears watchdog and power-down, sets time-out.
// - Pins keep their pre-sleep drive state.
// - Wake on master clear, watchdog, interrupt.
// - Only listed peripherals may wake the device.
// - Clock-based peripherals raise no interrupt asleep.
// - Master clear resets; others resume execution.
// - Power-down flag set at power-up, sleep clears.
// - Watchdog wake clears the time-out flag.
// - Sleep prefetches instruction at PC plus two.
// - Wake needs source enable, ignores global enable.
// - Resume next instruction, vector if global enable.
// - Pending enabled flag turns sleep into no-op.
// - Flag during sleep: complete sleep, wake at once.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module swc_sleep_ctrl
    import swc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Core side.
    input  wire logic        sleep_exec_i,
    input  wire logic [15:0] pc_i,
    output logic             prefetch_req_o,
    output logic      [15:0] prefetch_addr_o,
    output logic             core_run_o,
    output logic             resume_o,
    output logic             resume_vector_o,
    output logic             device_reset_o,
    // Oscillator and watchdog.
    input  wire logic        osc_stable_i,
    output logic             osc_run_o,
    input  wire logic        wdt_timeout_i,
    output logic             wdt_run_o,
    output logic             wdt_clear_o,
    // Wake sources.
    input  wire logic        master_clear_pin_i,
    input  wire logic        int_pin_flag_i,
    input  wire logic        port_b_change_i,
    input  wire logic [10:0] periph_flag_i,
    input  wire logic        clocked_periph_irq_i,
    output logic             clocked_periph_irq_o,
    // Port pins.
    input  wire logic [7:0]  io_out_i,
    input  wire logic [7:0]  io_oe_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    swc_state_e        state_q;
    swc_wake_e         wake_q;
    swc_wb_req_s       req;
    logic [CTRL_W-1:0] ctrl_q;
    logic [PER_W-1:0]  pen_q;
    logic              power_down_flag_q;
    logic              timeout_flag_q;
    logic [EV_W-1:0]   ev_st_q;
    logic [EV_W-1:0]   ev_msk_q;
    logic [EV_W-1:0]   ev_set;
    logic              acc;
    logic              wr;
    logic              int_pending;
    logic              commit;
    logic              noop;
    logic              wdt_wake;
    logic              int_wake;
    logic              master_clear_pin_wake;
    logic              resume_go;
    logic              global_int_enable;
    logic [31:0]       rdata;

    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i,
                   dat: wb_dat_i};
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = acc & req.we;
    assign global_int_enable = ctrl_q[CTRL_GIE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Wake qualification.
    // Each source counts only with its own enable; global enable is
    // not consulted here.
    assign int_pending = (int_pin_flag_i & ctrl_q[CTRL_INTE_BIT])
                       | (port_b_change_i & ctrl_q[CTRL_PBE_BIT])
                       | (|(periph_flag_i & pen_q));

    assign noop   = (state_q == ST_RUN) & sleep_exec_i & int_pending;
    assign commit = (state_q == ST_RUN) & sleep_exec_i & ~int_pending;

    // Master clear outranks the watchdog, which outranks interrupts.
    assign master_clear_pin_wake = (state_q == ST_SLEEP) & master_clear_pin_i;
    assign wdt_wake  = (state_q == ST_SLEEP) & ~master_clear_pin_i
                     & wdt_timeout_i & ctrl_q[CTRL_WDTE_BIT];
    assign int_wake  = (state_q == ST_SLEEP) & ~master_clear_pin_i
                     & ~wdt_wake & int_pending;
    assign resume_go = (state_q == ST_WAKE) & osc_stable_i;

    // No internal clock runs asleep, so these stay quiet.
    assign clocked_periph_irq_o = clocked_periph_irq_i
                                & (state_q == ST_RUN);

    // The watchdog runs on its own clock and is not stopped by sleep; it runs while the watchdog enable bit is set.
    assign wdt_run_o  = ctrl_q[CTRL_WDTE_BIT];
    assign core_run_o = (state_q == ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_RUN;
            wake_q  <= WK_INT;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (commit) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (master_clear_pin_wake) begin
                        state_q <= ST_WAKE;
                        wake_q  <= WK_MASTER_CLEAR_PIN;
                    end else if (wdt_wake) begin
                        state_q <= ST_WAKE;
                        wake_q  <= WK_WDT;
                    end else if (int_wake) begin
                        state_q <= ST_WAKE;
                        wake_q  <= WK_INT;
                    end
                end
                ST_WAKE: begin
                    if (resume_go) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Oscillator driver off from commit until a wake event.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_run_o <= 1'b1;
        end else if (commit) begin
            osc_run_o <= 1'b0;
        end else if (master_clear_pin_wake | wdt_wake | int_wake) begin
            osc_run_o <= 1'b1;
        end
    end

    // Resume pulses; master clear gives a reset instead.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resume_o        <= 1'b0;
            resume_vector_o <= 1'b0;
            device_reset_o  <= 1'b0;
        end else begin
            resume_o        <= resume_go & (wake_q != WK_MASTER_CLEAR_PIN);
            resume_vector_o <= resume_go & (wake_q == WK_INT) & global_int_enable;
            device_reset_o  <= resume_go & (wake_q == WK_MASTER_CLEAR_PIN);
        end
    end

    // Watchdog clear on a committed sleep; prefetch on every sleep instruction.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_o     <= 1'b0;
            prefetch_req_o  <= 1'b0;
            prefetch_addr_o <= 16'h0000;
        end else begin
            wdt_clear_o    <= commit;
            prefetch_req_o <= noop | commit;
            if (noop | commit) begin
                prefetch_addr_o <= pc_i + PREFETCH_STEP;
            end
        end
    end

    // Pins follow the port while running and freeze asleep.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= 8'h00;
            pin_oe_o  <= 8'h00;
        end else if (state_q == ST_RUN) begin
            pin_out_o <= io_out_i;
            pin_oe_o  <= io_oe_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down and time-out flags.
    // Software may set either flag by writing a one; hardware clears win.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_flag_q <= PD_RST;
            timeout_flag_q    <= TO_RST;
        end else begin
            if (commit) begin
                power_down_flag_q <= 1'b0;
            end else if (wr & (req.adr == RESET_CONTROL_REG_OFS) & req.sel[0]
                         & req.dat[RESET_CONTROL_REG_PD_BIT]) begin
                power_down_flag_q <= 1'b1;
            end
            if (wdt_wake) begin
                timeout_flag_q <= 1'b0;
            end else if (commit) begin
                timeout_flag_q <= 1'b1;
            end else if (wr & (req.adr == RESET_CONTROL_REG_OFS) & req.sel[0]
                         & req.dat[RESET_CONTROL_REG_TO_BIT]) begin
                timeout_flag_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= CTRL_RST;
            pen_q    <= PEN_RST;
            ev_msk_q <= EV_RST;
        end else if (wr) begin
            if (req.adr == CTRL_OFS && req.sel[0]) begin
                ctrl_q <= req.dat[CTRL_W-1:0];
            end
            if (req.adr == PEN_OFS) begin
                if (req.sel[0]) begin
                    pen_q[7:0] <= req.dat[7:0];
                end
                if (req.sel[1]) begin
                    pen_q[PER_W-1:8] <= req.dat[PER_W-1:8];
                end
            end
            if (req.adr == IRQ_MSK_OFS && req.sel[0]) begin
                ev_msk_q <= req.dat[EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, write one to clear; a new event beats the clear.
    always_comb begin
        ev_set           = '0;
        ev_set[EV_SLEEP] = commit;
        ev_set[EV_WINT]  = int_wake;
        ev_set[EV_WWDT]  = wdt_wake;
        ev_set[EV_NOP]   = noop;
        ev_set[EV_MASTER_CLEAR_PIN]  = master_clear_pin_wake;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_st_q <= EV_RST;
        end else if (wr & (req.adr == IRQ_ST_OFS) & req.sel[0]) begin
            ev_st_q <= (ev_st_q & ~req.dat[EV_W-1:0]) | ev_set;
        end else begin
            ev_st_q <= ev_st_q | ev_set;
        end
    end

    assign irq_o = |(ev_st_q & ev_msk_q);

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, unmapped addresses read zero.
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (req.adr)
            CTRL_OFS:    rdata[CTRL_W-1:0] = ctrl_q;
            PEN_OFS:     rdata[PER_W-1:0]  = pen_q;
            RESET_CONTROL_REG_OFS: begin
                rdata[RESET_CONTROL_REG_ASLEEP_BIT] = (state_q != ST_RUN);
                rdata[RESET_CONTROL_REG_PD_BIT]     = power_down_flag_q;
                rdata[RESET_CONTROL_REG_TO_BIT]     = timeout_flag_q;
            end
            IRQ_ST_OFS:  rdata[EV_W-1:0]   = ev_st_q;
            IRQ_MSK_OFS: rdata[EV_W-1:0]   = ev_msk_q;
            default:     rdata             = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            if (acc & ~req.we) begin
                wb_dat_o <= rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_sleep_commit;
        @(posedge clk_i) disable iff (rst_i)
        commit |=> wdt_clear_o && !power_down_flag_q && timeout_flag_q
                   && !osc_run_o && state_q == ST_SLEEP;
    endproperty
    a_sleep_commit: assert property (p_sleep_commit)
        else $error("sleep commit effects missing");

    property p_pin_hold;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SLEEP && $past(state_q) == ST_SLEEP)
            |-> $stable(pin_out_o) && $stable(pin_oe_o);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pins changed while asleep");

    property p_wdt_wake;
        @(posedge clk_i) disable iff (rst_i)
        wdt_wake |=> !timeout_flag_q && state_q == ST_WAKE && osc_run_o;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake)
        else $error("watchdog wake did not clear timeout flag");

    property p_nop_sleep;
        @(posedge clk_i) disable iff (rst_i)
        noop |=> state_q == ST_RUN && !wdt_clear_o
                 && $stable(power_down_flag_q) && prefetch_req_o;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep)
        else $error("no-op sleep changed state");

    property p_prefetch;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_exec_i && state_q == ST_RUN)
            |=> prefetch_addr_o == $past(pc_i) + PREFETCH_STEP;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("prefetch address wrong");

    property p_master_clear_pin_reset;
        @(posedge clk_i) disable iff (rst_i)
        (resume_go && wake_q == WK_MASTER_CLEAR_PIN) |=> device_reset_o && !resume_o;
    endproperty
    a_master_clear_pin_reset: assert property (p_master_clear_pin_reset)
        else $error("master clear did not reset");

    property p_vector;
        @(posedge clk_i) disable iff (rst_i)
        resume_vector_o |-> resume_o && $past(global_int_enable);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector without global enable");

    property p_wait_osc;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_WAKE && !osc_stable_i) |=> state_q == ST_WAKE;
    endproperty
    a_wait_osc: assert property (p_wait_osc)
        else $error("resumed before oscillator stable");

    property p_int_wake_now;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SLEEP && int_pending) |=> state_q == ST_WAKE;
    endproperty
    a_int_wake_now: assert property (p_int_wake_now)
        else $error("enabled interrupt did not wake");

    property p_clk_irq_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (state_q != ST_RUN) |-> !clocked_periph_irq_o;
    endproperty
    a_clk_irq_quiet: assert property (p_clk_irq_quiet)
        else $error("clocked peripheral irq while asleep");

endmodule
`default_nettype wire

// ===== tb/swc_far_model.sv
// Purpose: Far-side model: oscillator start-up and watchdog counter.
// Assumes: Runs on the controller clock; counts are short parameters.
// Notes:   The oscillator is only stable a while after its driver is on.
`timescale 1ns/10ps
`default_nettype none
module swc_far_model #(
    parameter int OSC_DLY = 3,
    parameter int WDT_LIM = 40
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Controller side.
    input  wire logic osc_run_i,
    input  wire logic wdt_run_i,
    input  wire logic wdt_clear_i,
    output logic      osc_stable_o,
    output logic      wdt_timeout_o
);
    int osc_cnt_q;
    int wdt_cnt_q;
    // The oscillator stands still while its driver is off.
    always_ff @(posedge clk_i) begin
        if (rst_i || !osc_run_i)
            osc_cnt_q <= 0;
        else if (osc_cnt_q < OSC_DLY)
            osc_cnt_q <= osc_cnt_q + 1;
    end
    assign osc_stable_o = osc_run_i && (osc_cnt_q == OSC_DLY);
    // The watchdog keeps counting while asleep.
    always_ff @(posedge clk_i) begin
        if (rst_i || !wdt_run_i || wdt_clear_i || wdt_timeout_o)
            wdt_cnt_q <= 0;
        else
            wdt_cnt_q <= wdt_cnt_q + 1;
    end
    assign wdt_timeout_o = wdt_run_i && (wdt_cnt_q == WDT_LIM);
endmodule
`default_nettype wire

// ===== tb/sleep_wake_control_tb.sv
// Purpose: Self-checking bench for the sleep and wake controller.
// Assumes: Wishbone master waits for ack; inputs change by NBA at edges.
// Notes:   Each scenario is one task.
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_control_tb;
    import swc_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, sleep_ex, osc_ok, wdt_to, master_clear_pin;
    logic int_f, pb_f, cper_i, ack, irq, pf_req, core_run, resume, vec;
    logic dev_rst, osc_run, wdt_run, wdt_clr, cper_o;
    logic [7:0]  adr, io_out, io_oe, pin_out, pin_oe;
    logic [15:0] pc, pf_addr;
    logic [10:0] pflag;
    logic [31:0] wdat, dat_o, rdat;
    int          bad_count, n_checks;

    swc_sleep_ctrl i_swc_sleep_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .sleep_exec_i(sleep_ex), .pc_i(pc), .prefetch_req_o(pf_req),
        .prefetch_addr_o(pf_addr), .core_run_o(core_run),
        .resume_o(resume), .resume_vector_o(vec),
        .device_reset_o(dev_rst), .osc_stable_i(osc_ok),
        .osc_run_o(osc_run), .wdt_timeout_i(wdt_to), .wdt_run_o(wdt_run),
        .wdt_clear_o(wdt_clr), .master_clear_pin_i(master_clear_pin),
        .int_pin_flag_i(int_f), .port_b_change_i(pb_f),
        .periph_flag_i(pflag), .clocked_periph_irq_i(cper_i),
        .clocked_periph_irq_o(cper_o), .io_out_i(io_out),
        .io_oe_i(io_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe));

    swc_far_model i_swc_far_model (
        .clk_i(clk_i), .rst_i(rst_i), .osc_run_i(osc_run),
        .wdt_run_i(wdt_run), .wdt_clear_i(wdt_clr),
        .osc_stable_o(osc_ok), .wdt_timeout_o(wdt_to));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0; stb <= 0;
    endtask

    task automatic sleep_go(input logic [15:0] p);
        @(posedge clk_i);
        sleep_ex <= 1; pc <= p;
        @(posedge clk_i);
        sleep_ex <= 0;
        #1;
    endtask

    task automatic wait_wake();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (resume !== 1 && dev_rst !== 1 && n < 200);
        if (n >= 200) bad_count++;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("osc", osc_run, 1);
        wb(1, 8'h14, 32'hFFFF_FFFF);
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0018);
    endtask

    task automatic t_nop();
        wb(1, CTRL_OFS, 32'h0000_0004);
        @(posedge clk_i); int_f <= 1;
        sleep_go(16'h1230);
        chk("pf_req", pf_req, 1);
        chk("pf_adr", pf_addr, 16'h1232);
        chk("run", core_run, 1);
        chk("wclr", wdt_clr, 0);
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0018);
        wb(0, IRQ_ST_OFS, 0); chk("nop", rdat[EV_NOP], 1);
        chk("irq_mask", irq, 0);
        @(posedge clk_i); int_f <= 0;
        wb(1, IRQ_ST_OFS, 32'h0000_001F);
    endtask

    task automatic t_int(input logic [3:0] ctl, input logic pb);
        wb(1, CTRL_OFS, {28'h0, ctl});
        wb(1, IRQ_MSK_OFS, 32'h0000_0001);
        @(posedge clk_i); io_out <= 8'hA5; io_oe <= 8'h0F; cper_i <= 1;
        repeat (2) @(posedge clk_i);
        #1;
        chk("cper", cper_o, 1);
        sleep_go(16'h0400);
        chk("wclr", wdt_clr, 1);
        chk("osc", osc_run, 0);
        chk("run", core_run, 0);
        @(posedge clk_i); io_out <= 8'h5A; io_oe <= 8'hF0;
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0011);
        chk("irq", irq, 1);
        chk("pin", {pin_oe, pin_out}, 16'h0FA5);
        chk("cper", cper_o, 0);
        @(posedge clk_i);
        if (pb) pb_f <= 1;
        else int_f <= 1;
        wait_wake();
        chk("resume", resume, 1);
        chk("vec", vec, ctl[CTRL_GIE_BIT]);
        chk("osc_ok", osc_ok, 1);
        @(posedge clk_i); int_f <= 0; pb_f <= 0;
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0010);
        chk("pin", {pin_oe, pin_out}, 16'hF05A);
        wb(1, IRQ_ST_OFS, 32'h0000_001F); #1;
        chk("irq", irq, 0);
    endtask

    task automatic t_late();
        wb(1, CTRL_OFS, 32'h0000_0004);
        @(posedge clk_i); sleep_ex <= 1; pc <= 16'h0200;
        @(posedge clk_i); sleep_ex <= 0; int_f <= 1;
        #1;
        chk("wclr", wdt_clr, 1);
        wait_wake();
        chk("resume", resume, 1);
        @(posedge clk_i); int_f <= 0;
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0010);
    endtask

    task automatic t_periph();
        wb(1, CTRL_OFS, 0);
        for (int k = 0; k < PER_W; k++) begin
            wb(1, PEN_OFS, 32'h1 << k);
            sleep_go(16'h0800);
            @(posedge clk_i); pflag <= ~(11'h1 << k); int_f <= 1; pb_f <= 1;
            repeat (5) @(posedge clk_i);
            #1;
            chk("asleep", core_run, 0);
            @(posedge clk_i); pflag <= 11'h7FF;
            wait_wake();
            chk("pwake", resume, 1);
            chk("vec", vec, 0);
            @(posedge clk_i); pflag <= 0; int_f <= 0; pb_f <= 0;
        end
        wb(1, PEN_OFS, 0);
    endtask

    task automatic t_wdt();
        wb(1, CTRL_OFS, 32'h0000_0002);
        sleep_go(16'h0100);
        chk("wrun", wdt_run, 1);
        wait_wake();
        chk("resume", resume, 1);
        chk("dev_rst", dev_rst, 0);
        wb(0, RESET_CONTROL_REG_OFS, 0); chk("reset_control_reg", rdat, 32'h0000_0000);
        wb(0, IRQ_ST_OFS, 0); chk("wwake", rdat[EV_WWDT], 1);
        wb(1, CTRL_OFS, 0);
    endtask

    task automatic t_master_clear_pin();
        sleep_go(16'h0300);
        @(posedge clk_i); master_clear_pin <= 1;
        wait_wake();
        chk("dev_rst", dev_rst, 1);
        chk("resume", resume, 0);
        @(posedge clk_i); master_clear_pin <= 0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_sim();
    end

    initial begin
        bad_count = 0; n_checks = 0; rst_i = 1; cyc = 0; stb = 0; we = 0;
        adr = 0; wdat = 0; sleep_ex = 0; pc = 0; master_clear_pin = 0; int_f = 0;
        pb_f = 0; pflag = 0; cper_i = 0; io_out = 0; io_oe = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_nop();
        t_int(4'h5, 1'b0);
        t_int(4'h8, 1'b1);
        t_late();
        t_periph();
        t_wdt();
        t_master_clear_pin();
        end_sim();
    end
endmodule
`default_nettype wire
